// ---- include/protect_defs.vh ----
// constants for the block write-protection logic
`ifndef PROTECT_DEFS_VH
`define PROTECT_DEFS_VH
// command opcodes
`define OP_WRITE_STATUS     8'h01
`define OP_WRITE_ENABLE     8'h06
`define OP_WRITE_DISABLE    8'h04
`define OP_READ_PARAMS_VOL  8'hc0
`define OP_BANK_ADDR_VOL    8'h17
`define OP_WHOLE_ERASE_A    8'hc7
`define OP_WHOLE_ERASE_B    8'h60
// status register bit positions
`define SR_CODE_LSB         2
`define SR_QUAD_BIT         6
`define SR_SWD_BIT          7
`define SR_RESET            8'h00
// map sizes in blocks
`define STD_BLOCKS          13'h1000
`define BIG_BLOCKS          13'h0400
// wishbone register byte addresses
`define ADDR_CMD            4'h0
`define ADDR_STATUS         4'h4
`define ADDR_CONFIG         4'h8
`define ADDR_RESULT         4'hc
// command register fields
`define CMD_OP_LSB          0
`define CMD_DATA_LSB        8
`define CMD_BLOCK_LSB       16
// config register bits
`define CFG_BIG_BIT         0
`define CFG_TBS_BIT         1
`endif

// ---- src/block_write_protect.v ----
// block write-protection logic with wishbone command and status access
// Notes on behaviour
// - volatile read-params C0h and bank-address 17h need no write enable.
// - program or erase inside a nonzero protected range is inhibited.
// - whole-array erase ignored unless all four protect bits are zero.
// - with write-disable bit 0 the status register is writable regardless of pin.
// - write-disable 1 and protect pin low locks status; write-status ignored.
// - write-disable 1 and protect pin high lets write-status proceed.
// - quad enable 0 uses protect and hold pins; 1 makes them lanes 2 and 3, but here the protect pin level still locks status when quad enable is 1.
// - quad enable is held in the status register, changed only by write-status.
// - standard map: code 0 none, codes 1..12 protect 2^(code-1) blocks.
// - standard map: code 13 protects 3072, 14 protects 3584, 15 all.
// - top select grows down from last block; bottom grows up from block 0.
// - 1024-block map: codes 1..10 protect 2^(code-1), code 11 all.
// - 1024-block map: both upper code bits set protects all blocks.
// - top/bottom select is one-time: once bottom it never returns to top.
// - protect, quad and write-disable bits change only by 01h after enable.
//
// Design decisions made here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "protect_defs.vh"
module block_write_protect (
    input  wire        mclk,         // 250 MHz system clock
    input  wire        nrst,         // async reset, active low
    input  wire        wb_cyc_i,     // wishbone cycle
    input  wire        wb_stb_i,     // wishbone strobe
    input  wire        wb_we_i,      // wishbone write
    input  wire [3:0]  wb_adr_i,     // wishbone byte address
    input  wire [3:0]  wb_sel_i,     // wishbone byte selects
    input  wire [31:0] wb_dat_i,     // wishbone write data
    output reg  [31:0] wb_dat_o,     // wishbone read data
    output reg         wb_ack_o,     // wishbone acknowledge
    input  wire        wp_pin_i,     // write-protect pin level
    input  wire        hold_pin_i,   // hold/reset pin level
    output reg         wp_func_o,    // protect pin acts as write protect
    output reg         hold_func_o,  // hold/reset function active
    output reg         lane2_en_o,   // quad_data_lane_2 enabled
    output reg         lane3_en_o,   // quad_data_lane_3 enabled
    output reg         array_go_o,   // one-cycle start of array operation
    output reg  [7:0]  array_op_o    // opcode of started operation
);
    reg  [7:0]  status_r;
    reg         write_en_latch_r;
    reg         top_bottom_select_r;
    reg         big_map_r;
    reg  [2:0]  result_r;
    reg  [7:0]  read_params_r;
    reg  [7:0]  bank_addr_r;
    reg         hold_seen_r;
    wire        wp_level;
    wire        hold_level;
    wire        hit;
    wire        req;
    wire        wr_cmd;
    wire [7:0]  op;
    wire [7:0]  arg;
    wire [11:0] blk;
    wire [3:0]  protect_code;
    wire        status_write_disable;
    wire        quad_lane_enable;
    wire        is_prog_erase;
    wire        is_whole_erase;
    wire        status_locked;

    pin_sync u_wp_sync (
        .mclk (mclk),
        .nrst (nrst),
        .din  (wp_pin_i),
        .dout (wp_level)
    );

    pin_sync u_hold_sync (
        .mclk (mclk),
        .nrst (nrst),
        .din  (hold_pin_i),
        .dout (hold_level)
    );

    assign protect_code         = status_r[`SR_CODE_LSB +: 4];
    assign status_write_disable = status_r[`SR_SWD_BIT];
    assign quad_lane_enable     = status_r[`SR_QUAD_BIT];
    assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_cmd = req & wb_we_i & (wb_adr_i == `ADDR_CMD) & (&wb_sel_i[2:0]);
    assign op     = wb_dat_i[`CMD_OP_LSB +: 8];
    assign arg    = wb_dat_i[`CMD_DATA_LSB +: 8];
    assign blk    = wb_dat_i[`CMD_BLOCK_LSB +: 12];

    range_decode u_range (
        .code       (protect_code),
        .top_bottom (top_bottom_select_r),
        .big_blocks (big_map_r),
        .block      (blk),
        .hit        (hit)
    );

    // program and block/sector erase opcodes that carry a target block
    assign is_prog_erase = (op == 8'h02) | (op == 8'h12) | (op == 8'h32) |
                           (op == 8'h34) | (op == 8'h38) | (op == 8'h3e) |
                           (op == 8'hd7) | (op == 8'h20) | (op == 8'h21) |
                           (op == 8'h52) | (op == 8'h5c) | (op == 8'hd8) |
                           (op == 8'hdc);
    assign is_whole_erase = (op == `OP_WHOLE_ERASE_A) | (op == `OP_WHOLE_ERASE_B);
    assign status_locked  = status_write_disable & ~wp_level;

    // result codes: 0 done, 1 no write enable, 2 protected, 3 locked, 4 unknown
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wb_ack_o            <= 1'b0;
            wb_dat_o            <= 32'h00000000;
            status_r            <= `SR_RESET;
            write_en_latch_r    <= 1'b0;
            top_bottom_select_r <= 1'b0;
            big_map_r           <= 1'b0;
            result_r            <= 3'h0;
            read_params_r       <= 8'h00;
            bank_addr_r         <= 8'h00;
            array_go_o          <= 1'b0;
            array_op_o          <= 8'h00;
        end else begin
            wb_ack_o   <= req;
            array_go_o <= 1'b0;
            if (req && !wb_we_i) begin
                case (wb_adr_i)
                    `ADDR_STATUS: wb_dat_o <= {20'h00000, wp_level, hold_seen_r,
                                               write_en_latch_r, 1'b0, status_r};
                    `ADDR_CONFIG: wb_dat_o <= {30'h00000000, top_bottom_select_r, big_map_r};
                    `ADDR_RESULT: wb_dat_o <= {13'h0000, read_params_r, bank_addr_r,
                                               result_r};
                    default:      wb_dat_o <= 32'h00000000;
                endcase
            end
            if (req && wb_we_i && wb_adr_i == `ADDR_CONFIG && wb_sel_i[0]) begin
                big_map_r <= wb_dat_i[`CFG_BIG_BIT];
                if (wb_dat_i[`CFG_TBS_BIT]) begin
                    top_bottom_select_r <= 1'b1;
                end
            end
            if (wr_cmd) begin
                result_r <= 3'h0;
                if (op == `OP_WRITE_ENABLE) begin
                    write_en_latch_r <= 1'b1;
                end else if (op == `OP_WRITE_DISABLE) begin
                    write_en_latch_r <= 1'b0;
                end else if (op == `OP_READ_PARAMS_VOL) begin
                    read_params_r <= arg;
                end else if (op == `OP_BANK_ADDR_VOL) begin
                    bank_addr_r <= arg;
                end else if (op == `OP_WRITE_STATUS) begin
                    if (!write_en_latch_r) begin
                        result_r <= 3'h1;
                    end else if (status_locked) begin
                        result_r <= 3'h3;
                    end else begin
                        status_r         <= arg & 8'hfc;
                        write_en_latch_r <= 1'b0;
                    end
                end else if (is_whole_erase || is_prog_erase) begin
                    if (!write_en_latch_r) begin
                        result_r <= 3'h1;
                    end else if (is_whole_erase && protect_code != 4'h0) begin
                        result_r <= 3'h2;
                    end else if (is_prog_erase && hit) begin
                        result_r <= 3'h2;
                    end else begin
                        array_go_o       <= 1'b1;
                        array_op_o       <= op;
                        write_en_latch_r <= 1'b0;
                    end
                end else begin
                    result_r <= 3'h4;
                end
            end
        end
    end

    // pin function selection follows quad enable
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wp_func_o   <= 1'b1;
            hold_func_o <= 1'b1;
            lane2_en_o  <= 1'b0;
            lane3_en_o  <= 1'b0;
            hold_seen_r <= 1'b0;
        end else begin
            wp_func_o   <= ~quad_lane_enable;
            hold_func_o <= ~quad_lane_enable;
            lane2_en_o  <= quad_lane_enable;
            lane3_en_o  <= quad_lane_enable;
            hold_seen_r <= ~quad_lane_enable & ~hold_level;
        end
    end
endmodule

// ---- src/pin_sync.v ----
// three-stage synchroniser; a change counts once stages two and three agree
`timescale 1ns/1ps
`include "protect_defs.vh"
module pin_sync (
    input  wire mclk,   // system clock
    input  wire nrst,   // async reset, active low
    input  wire din,    // asynchronous pin level
    output reg  dout    // filtered level
);
    reg s1_r;
    reg s2_r;
    reg s3_r;
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            // start at the idle high level so no false change follows reset
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
            dout <= 1'b1;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                dout <= s3_r;
            end
        end
    end
endmodule

// ---- src/range_decode.v ----
// decides whether a block index falls inside the protected range
`timescale 1ns/1ps
`include "protect_defs.vh"
module range_decode (
    input  wire [3:0]  code,       // protect code
    input  wire        top_bottom, // 0 top end, 1 bottom end
    input  wire        big_blocks, // 1024-block map
    input  wire [11:0] block,      // target block index
    output reg         hit         // block is protected
);
    reg [12:0] count;
    reg [12:0] total;
    always @* begin
        total = big_blocks ? `BIG_BLOCKS : `STD_BLOCKS;
        count = 13'h0000;
        if (code != 4'h0) begin
            count = 13'h0001 << (code - 4'h1);
        end
        if (big_blocks) begin
            if (code >= 4'hb) begin
                count = `BIG_BLOCKS;
            end
        end else begin
            case (code)
                4'hd:    count = 13'h0c00;
                4'he:    count = 13'h0e00;
                4'hf:    count = `STD_BLOCKS;
                default: count = count;
            endcase
        end
        if (big_blocks && block[11:10] != 2'b00) begin
            hit = 1'b0;
        end else if (top_bottom) begin
            hit = ({1'b0, block} < count);
        end else begin
            hit = ({1'b0, block} >= total - count);
        end
    end
endmodule

// ---- test/block_write_protect_sva.sv ----
// concurrent checks on the block write-protection ports
`timescale 1ns/1ps
module block_write_protect_sva (
    input wire        mclk,
    input wire        nrst,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [3:0]  wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        wp_func_o,
    input wire        hold_func_o,
    input wire        lane2_en_o,
    input wire        lane3_en_o,
    input wire        array_go_o,
    input wire [7:0]  array_op_o
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
    AST_ACK_ONE: assert property (s_req |=> s_ans) else $error("ack not one cycle after request");
    AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    AST_GO_PULSE: assert property (array_go_o |=> !array_go_o) else $error("start too long");
    AST_GO_CMD: assert property (array_go_o |-> wb_ack_o && $past(wb_we_i && wb_adr_i == 4'h0))
        else $error("start without command write");
    AST_GO_OP: assert property (array_go_o |-> array_op_o == $past(wb_dat_i[7:0]))
        else $error("started opcode differs from command");
    AST_OP_HOLD: assert property (!array_go_o |-> $stable(array_op_o)) else $error("opcode moved");
    AST_PIN_MODE: assert property (lane2_en_o == lane3_en_o && wp_func_o == !lane2_en_o)
        else $error("pin mode and lanes disagree");
    AST_HOLD_MODE: assert property (hold_func_o == wp_func_o) else $error("hold mode off");
    AST_UNMAPPED: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i[1:0] != 2'h0)
        |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
endmodule
bind block_write_protect block_write_protect_sva i_sva (.mclk, .nrst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wp_func_o, .hold_func_o,
    .lane2_en_o, .lane3_en_o, .array_go_o, .array_op_o);

// ---- test/block_write_protect_tb.sv ----
// self-checking bench for the block write-protection logic
`timescale 1ns/1ps
module block_write_protect_tb;
    logic        mclk = 0, nrst = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wp_lvl = 1;
    logic [3:0]  wb_adr_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o, q;
    logic        wb_ack_o, wp_pin, hold_pin, go, wp_func_o, hold_func_o;
    logic        lane2_en_o, lane3_en_o, array_go_o;
    logic [7:0]  array_op_o;
    logic        hold_lvl = 1;
    int          errors = 0, checks = 0, i;
    logic [7:0]  ops [13] = '{8'h02, 8'h12, 8'h32, 8'h34, 8'h38, 8'h3e, 8'hd7, 8'h20,
                              8'h21, 8'h52, 8'h5c, 8'hd8, 8'hdc};
    always #2 mclk = ~mclk;
    pin_host i_pin_host (.mclk, .nrst, .wp_lvl, .hold_lvl, .wp_pin, .hold_pin);
    block_write_protect i_block_write_protect (.mclk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .wp_pin_i(wp_pin),
        .hold_pin_i(hold_pin), .wp_func_o, .hold_func_o, .lane2_en_o, .lane3_en_o,
        .array_go_o, .array_op_o);
    task results;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            errors++;
            results();
        end else begin
            q = wb_dat_o;
            go = array_go_o;
            wb_cyc_i <= 0;
            wb_stb_i <= 0;
        end
    endtask
    // eg 2 leaves the start pulse unchecked
    task cmd(input logic [7:0] op, input logic [7:0] arg, input int blk, input int res,
             input int eg);
        logic g;
        wb(1, 4'h0, {4'h0, blk[11:0], arg, op});
        g = go;
        wb(0, 4'hc, 0);
        chk("result", res, q[2:0]);
        if (eg < 2)
            chk("array go", eg, g);
        if (eg == 1)
            chk("array op", op, array_op_o);
    endtask
    task sts(input logic [7:0] v, input int res);
        cmd(8'h06, 0, 0, 0, 0);
        cmd(8'h01, v, 0, res, 2);
    endtask
    function int nblk(input int c, input bit big);
        if (c == 0) return 0;
        if (big) return (c <= 10) ? 1 << (c - 1) : 1024;
        if (c <= 12) return 1 << (c - 1);
        return (c == 13) ? 3072 : (c == 14) ? 3584 : 4096;
    endfunction
    // probe both edges of the protected range for every partial code
    task sweep(input bit big, input bit bot);
        int c, n, t;
        t = big ? 1024 : 4096;
        for (c = 0; c < 16; c++) begin
            n = nblk(c, big);
            sts(8'(c << 2), 0);
            if (n > 0) begin
                cmd(8'h06, 0, 0, 0, 0);
                cmd(ops[c % 13], 0, bot ? n - 1 : t - n, 2, 0);
            end
            if (n < t) begin
                cmd(8'h06, 0, 0, 0, 0);
                cmd(ops[(c + 5) % 13], 0, bot ? n : t - n - 1, 0, 1);
            end
        end
    endtask
    initial begin
        repeat (16) @(posedge mclk);
        nrst <= 1;
        repeat (8) @(posedge mclk);
        cmd(8'hc0, 8'h5a, 0, 0, 0);
        cmd(8'h17, 8'h3c, 0, 0, 0);
        chk("bank", 8'h3c, q[10:3]);
        chk("params", 8'h5a, q[18:11]);
        cmd(8'h01, 8'h08, 0, 1, 2);
        wb(0, 4'h4, 0);
        chk("status", 0, q[7:0]);
        for (i = 0; i < 2; i++) begin
            sts(8'h04, 0);
            cmd(8'h06, 0, 0, 0, 0);
            cmd(i ? 8'h60 : 8'hc7, 0, 0, 2, 0);
            sts(8'h00, 0);
            cmd(8'h06, 0, 0, 0, 0);
            cmd(i ? 8'h60 : 8'hc7, 0, 0, 0, 1);
        end
        sts(8'h80, 0);
        wp_lvl <= 0;
        repeat (8) @(posedge mclk);
        sts(8'h40, 3);
        wb(0, 4'h4, 0);
        chk("status", 8'h80, q[7:0]);
        chk("status pins", 4'h2, q[11:8]);
        wp_lvl <= 1;
        repeat (8) @(posedge mclk);
        sts(8'h40, 0);
        wb(0, 4'h4, 0);
        chk("status", 8'h40, q[7:0]);
        chk("status pins", 4'h8, q[11:8]);
        chk("lanes", 2'b11, {lane2_en_o, lane3_en_o});
        chk("pin use", 2'b00, {wp_func_o, hold_func_o});
        wp_lvl <= 0;
        repeat (8) @(posedge mclk);
        sts(8'h00, 0);
        chk("pin use", 2'b11, {wp_func_o, hold_func_o});
        hold_lvl <= 0;
        repeat (8) @(posedge mclk);
        wb(0, 4'h4, 0);
        chk("hold seen", 1, q[10]);
        hold_lvl <= 1;
        wp_lvl <= 1;
        sweep(0, 0);
        wb(1, 4'h8, 32'h2);
        sweep(0, 1);
        wb(1, 4'h8, 32'h1);
        wb(0, 4'h8, 0);
        chk("config", 2'b11, q[1:0]);
        wb(0, 4'h1, 0);
        chk("unmapped", 0, q);
        sweep(1, 1);
        results();
    end
endmodule

// ---- test/pin_host.sv ----
// far-side model driving the protect and hold pin levels
`timescale 1ns/1ps
module pin_host (
    input  wire  mclk,     // system clock
    input  wire  nrst,     // reset, active low
    input  wire  wp_lvl,   // requested protect level
    input  wire  hold_lvl, // requested hold level
    output logic wp_pin,   // protect pin, high leaves status writable
    output logic hold_pin  // hold pin, high after reset then follows hold_lvl
);
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wp_pin <= 1'b1;
            hold_pin <= 1'b1;
        end else begin
            wp_pin <= wp_lvl;
            hold_pin <= hold_lvl;
        end
    end
endmodule
